/* core/asop_cfg.svh */
// constants for the serial output port of the converter
`ifndef ASOP_CFG_SVH
`define ASOP_CFG_SVH

`define ASOP_RES_W          16
`define ASOP_RESULT_RST     16'h0000
`define ASOP_MCLK_NS        5
`define ASOP_SCLK_PERIOD_NS 40
`define ASOP_PHASE_CYC      (`ASOP_SCLK_PERIOD_NS / (4 * `ASOP_MCLK_NS))
`define ASOP_FRAME_BITS     5'h10
`define ASOP_CHAIN_EDGE     5'h11
`define ASOP_PIN_B6         0
`define ASOP_PIN_B7         1
`define ASOP_PIN_B8         2
`define ASOP_PIN_B9         3
`define ASOP_PAR_LSB        6
`define ASOP_MSB_FLIP       16'h8000

`endif

/* core/asop_pkg.sv */
// types for the serial output port of the converter
package asop_pkg;

  typedef logic [15:0] asop_word_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_MASTER = 2'b01,
    ST_SLAVE  = 2'b10
  } asop_state_e;

endpackage

/* core/asop_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module asop_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* core/asop_port.sv */
// converter result output port: parallel bits 6..9 or serial port
`timescale 1ns/10ps
`default_nettype none
`include "asop_cfg.svh"

module asop_port #(
  parameter logic [7:0] PHASE_CYC = 8'(`ASOP_PHASE_CYC)
) (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                port_style_select,
  input  wire logic                clock_invert_select,
  input  wire logic                read_mode_or_chain_input,
  input  wire logic                clock_source_select,
  input  wire logic                output_code_format,
  input  wire logic                sclk_in,
  input  wire logic                read_select_n,
  input  wire logic                conv_start,
  input  wire logic                conv_done,
  input  wire asop_pkg::asop_word_t conv_result,
  output var  logic [3:0]          data_pin_o,
  output var  logic [3:0]          data_pin_oe_n,
  output var  logic                frame_active
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic asop_pkg::asop_word_t code_word(input asop_pkg::asop_word_t w,
                                                     input logic ocf);
    code_word = ocf ? w : (w ^ `ASOP_MSB_FLIP);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pins_s;
  logic       ser_s;
  logic       inv_s;
  logic       rdc_s;
  logic       slave_s;
  logic       ocf_s;
  logic       sclk_s;
  logic       rsel_n_s;

  asop_sync #(.W(7)) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .d       ({port_style_select, clock_invert_select, read_mode_or_chain_input,
               clock_source_select, output_code_format, sclk_in, !read_select_n}),
    .q       (pins_s)
  );

  assign ser_s    = pins_s[6];
  assign inv_s    = pins_s[5];
  assign rdc_s    = pins_s[4];
  assign slave_s  = pins_s[3];
  assign ocf_s    = pins_s[2];
  assign sclk_s   = pins_s[1];
  // select crosses active high so the reset value matches the idle pin
  assign rsel_n_s = ~pins_s[0];

  // ---------------------------------------------------------------
  // latest result and edge detection
  // ---------------------------------------------------------------
  asop_pkg::asop_word_t result_q;
  logic                 sclk_prev_q;
  logic                 rsel_prev_q;
  logic                 upd_edge;
  logic                 read_begin;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= `ASOP_RESULT_RST;
    end else if (conv_done) begin
      result_q <= conv_result;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b0;
      rsel_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      rsel_prev_q <= rsel_n_s;
    end
  end

  // data update edge follows clock invert select
  assign upd_edge   = inv_s ? (sclk_prev_q & ~sclk_s) : (~sclk_prev_q & sclk_s);
  assign read_begin = rsel_prev_q & ~rsel_n_s;

  // ---------------------------------------------------------------
  // master trigger selection
  // ---------------------------------------------------------------
  logic                 m_trig;
  asop_pkg::asop_word_t m_src;

  assign m_trig = rdc_s ? conv_start : conv_done;
  assign m_src  = rdc_s ? result_q : conv_result;

  // ---------------------------------------------------------------
  // frame state machine and shift register
  // ---------------------------------------------------------------
  asop_pkg::asop_state_e st_q;
  asop_pkg::asop_word_t  shreg_q;
  logic [4:0]            cnt_q;
  logic [1:0]            phase_q;
  logic [7:0]            pcnt_q;
  logic                  phase_end;

  assign phase_end = (pcnt_q == PHASE_CYC - 8'h01);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= asop_pkg::ST_IDLE;
      shreg_q <= `ASOP_RESULT_RST;
      cnt_q   <= 5'h00;
      phase_q <= 2'h0;
      pcnt_q  <= 8'h00;
    end else begin
      unique case (st_q)
        asop_pkg::ST_IDLE: begin
          phase_q <= 2'h0;
          pcnt_q  <= 8'h00;
          cnt_q   <= 5'h00;
          if (ser_s && !slave_s && !rsel_n_s && m_trig) begin
            shreg_q <= code_word(m_src, ocf_s);
            st_q    <= asop_pkg::ST_MASTER;
          end else if (ser_s && slave_s && read_begin) begin
            shreg_q <= code_word(result_q, ocf_s);
            st_q    <= asop_pkg::ST_SLAVE;
          end
        end
        asop_pkg::ST_MASTER: begin
          if (!ser_s || slave_s || rsel_n_s) begin
            st_q <= asop_pkg::ST_IDLE;
          end else if (phase_end) begin
            pcnt_q  <= 8'h00;
            phase_q <= phase_q + 2'h1;
            // data moves mid low phase, away from both clock edges
            if (phase_q == 2'h0 && cnt_q != 5'h00) begin
              shreg_q <= {shreg_q[14:0], 1'b0};
            end
            // frame ends mid low phase so the last bit spans both edges
            if (phase_q == 2'h0 && cnt_q == `ASOP_FRAME_BITS) begin
              st_q <= asop_pkg::ST_IDLE;
            end
            if (phase_q == 2'h3) begin
              cnt_q <= cnt_q + 5'h01;
            end
          end else begin
            pcnt_q <= pcnt_q + 8'h01;
          end
        end
        asop_pkg::ST_SLAVE: begin
          if (!ser_s || !slave_s || rsel_n_s) begin
            st_q <= asop_pkg::ST_IDLE;
          end else if (upd_edge) begin
            // first edge presents the msb, later edges shift in the chain
            if (cnt_q != 5'h00) begin
              shreg_q <= {shreg_q[14:0], rdc_s};
            end
            if (cnt_q != `ASOP_CHAIN_EDGE) begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        default: begin
          st_q <= asop_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  asop_pkg::asop_word_t par_word;
  logic                 serial_result_out;
  logic                 sclk_out;
  logic [3:0]           pin_d;
  logic [3:0]           oe_n_d;

  assign par_word = code_word(result_q, ocf_s);
  assign serial_result_out    = (st_q != asop_pkg::ST_IDLE) & shreg_q[15];
  assign sclk_out = ((st_q == asop_pkg::ST_MASTER) & phase_q[1]) ^ inv_s;

  always_comb begin
    pin_d  = 4'h0;
    oe_n_d = 4'hf;
    if (!ser_s) begin
      pin_d  = par_word[`ASOP_PAR_LSB +: 4];
      oe_n_d = 4'h0;
    end else begin
      pin_d[`ASOP_PIN_B8]  = serial_result_out;
      oe_n_d[`ASOP_PIN_B8] = 1'b0;
      pin_d[`ASOP_PIN_B9]  = slave_s ? 1'b0 : sclk_out;
      oe_n_d[`ASOP_PIN_B9] = slave_s;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      data_pin_o    <= 4'h0;
      data_pin_oe_n <= 4'hf;
      frame_active  <= 1'b0;
    end else begin
      data_pin_o    <= pin_d;
      data_pin_oe_n <= oe_n_d;
      frame_active  <= (st_q != asop_pkg::ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // master clock count per frame
  // ---------------------------------------------------------------
  logic [4:0] m_edges_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      m_edges_q <= 5'h00;
    end else if (st_q != asop_pkg::ST_MASTER) begin
      m_edges_q <= 5'h00;
    end else if (phase_end && phase_q == 2'h1) begin
      m_edges_q <= m_edges_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_par_pin_enable: assert property (!ser_s |=> data_pin_oe_n == 4'h0)
    else $error("parallel pins not driven");
  a_par_pin_data: assert property (!ser_s |=> data_pin_o == $past(par_word[9:6]))
    else $error("parallel pins do not show bits six to nine");
  a_sclk_invert: assert property ((ser_s && !slave_s && st_q == asop_pkg::ST_IDLE)
                                  |=> data_pin_o[3] == $past(inv_s))
    else $error("idle master clock level ignores invert select");
  a_chain_shift: assert property ((st_q == asop_pkg::ST_SLAVE && upd_edge && cnt_q != 5'h00
                                   && ser_s && slave_s && !rsel_n_s)
                                  |=> shreg_q[0] == $past(rdc_s))
    else $error("chain input not shifted in");
  a_master_prev: assert property ((st_q == asop_pkg::ST_IDLE && ser_s && !slave_s && !rsel_n_s
                                   && rdc_s && conv_start)
                                  |=> st_q == asop_pkg::ST_MASTER
                                      && shreg_q == $past(code_word(result_q, ocf_s)))
    else $error("previous result not sent during conversion");
  a_master_wait: assert property ((st_q == asop_pkg::ST_IDLE && !rdc_s && !conv_done)
                                  |=> st_q != asop_pkg::ST_MASTER)
    else $error("master frame started before conversion end");
  a_serial_result_out_pin: assert property (ser_s |=> data_pin_o[2] == $past(serial_result_out)
                                          && data_pin_oe_n[2] == 1'b0)
    else $error("serial output not on bit-eight pin");
  a_code_format: assert property ((st_q == asop_pkg::ST_IDLE && ser_s && slave_s && read_begin)
                                  |=> shreg_q[15] == ($past(result_q[15]) ^ !$past(ocf_s))
                                      && shreg_q[14:0] == $past(result_q[14:0]))
    else $error("result code format wrong");
  a_master_stable: assert property ((st_q == asop_pkg::ST_MASTER && $past(st_q) == asop_pkg::ST_MASTER
                                     && $changed(shreg_q))
                                    |-> $past(phase_q) == 2'h0)
    else $error("master data moved near a clock edge");
  a_slave_edge: assert property ((st_q == asop_pkg::ST_SLAVE && $past(st_q) == asop_pkg::ST_SLAVE
                                  && $changed(shreg_q))
                                 |-> $past(upd_edge))
    else $error("slave data moved off the update edge");
  a_clk_dir: assert property (ser_s |=> data_pin_oe_n[3] == $past(slave_s))
    else $error("clock pin direction wrong");
  a_frame_len: assert property ((st_q == asop_pkg::ST_MASTER && !rsel_n_s && ser_s && !slave_s
                                 && phase_end && phase_q == 2'h0 && cnt_q == `ASOP_FRAME_BITS)
                                |=> st_q == asop_pkg::ST_IDLE)
    else $error("master frame not sixteen bits");
  a_master_bits: assert property ((st_q == asop_pkg::ST_IDLE
                                   && $past(st_q) == asop_pkg::ST_MASTER
                                   && $past(ser_s && !slave_s && !rsel_n_s))
                                  |-> m_edges_q == `ASOP_FRAME_BITS)
    else $error("master frame clock count not sixteen");

  c_master_frame: cover property (st_q == asop_pkg::ST_MASTER ##1 st_q == asop_pkg::ST_IDLE);
  c_slave_chain: cover property (st_q == asop_pkg::ST_SLAVE && cnt_q == `ASOP_CHAIN_EDGE);
  c_parallel: cover property (!ser_s && conv_done);
  c_slave_invert: cover property (st_q == asop_pkg::ST_SLAVE && inv_s && upd_edge);
  c_master_rdc: cover property (st_q == asop_pkg::ST_IDLE && rdc_s && !slave_s && ser_s
                                && conv_start && !rsel_n_s);

endmodule

`default_nettype wire

/* testbench/asop_host_model.sv */
// host side of the serial port: clock source in slave mode, bit collector in both modes
`timescale 1ns/10ps
`default_nettype none

module asop_host_model (
  input  wire logic [3:0]  pins,
  input  wire logic        slave_mode,
  input  wire logic        invert,
  input  wire logic        go,
  output var  logic        sclk_in,
  output var  logic        read_select_n,
  output var  logic [31:0] rx_word,
  output var  int          rx_count
);
  // -----------------------------
  // select and idle clock level
  // -----------------------------
  assign read_select_n = !go;
  initial begin
    sclk_in = 1'b0;
    rx_word = 32'h0;
    rx_count = 0;
  end
  always @(go, invert) begin
    if (!go) begin
      sclk_in = invert;
    end
  end
  // -----------------------------
  // slave frame: twenty host clock periods of 80 ns, clock only while selected
  // -----------------------------
  always @(posedge go) begin
    rx_word = 32'h0;
    rx_count = 0;
    if (slave_mode) begin
      #100;
      repeat (20) begin
        #40 sclk_in = !sclk_in;
        #40 sclk_in = !sclk_in;
        rx_word = {rx_word[30:0], pins[2]};
        rx_count = rx_count + 1;
      end
    end
  end
  // -----------------------------
  // master frame: sample on rising edge of the pin clock
  // -----------------------------
  always @(posedge pins[3]) begin
    if (go && !slave_mode) begin
      rx_word = {rx_word[30:0], pins[2]};
      rx_count = rx_count + 1;
    end
  end
endmodule
`default_nettype wire

/* testbench/adc_serial_output_port_test.sv */
// self-checking bench of the converter result output port
`timescale 1ns/10ps
`default_nettype none

module adc_serial_output_port_test;
  logic mclk, reset_n, pss, cis, rmc, css, ocf, go, conv_start, conv_done;
  logic sclk_in, read_select_n, frame_active;
  logic [3:0] data_pin_o, data_pin_oe_n;
  logic [31:0] rx_word;
  int rx_count;
  asop_pkg::asop_word_t conv_result;
  int num_errors = 0;
  int checks_done = 0;

  asop_port uut (
    .mclk(mclk), .reset_n(reset_n), .port_style_select(pss),
    .clock_invert_select(cis), .read_mode_or_chain_input(rmc),
    .clock_source_select(css), .output_code_format(ocf), .sclk_in(sclk_in),
    .read_select_n(read_select_n), .conv_start(conv_start), .conv_done(conv_done),
    .conv_result(conv_result), .data_pin_o(data_pin_o),
    .data_pin_oe_n(data_pin_oe_n), .frame_active(frame_active)
  );
  asop_host_model host (
    .pins(data_pin_o), .slave_mode(css), .invert(cis), .go(go),
    .sclk_in(sclk_in), .read_select_n(read_select_n),
    .rx_word(rx_word), .rx_count(rx_count)
  );

  // -----------------------------
  // clock, compare and closing
  // -----------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = !mclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    conclude();
  end

  // -----------------------------
  // conversion pulses and one serial frame
  // -----------------------------
  task automatic conv(input asop_pkg::asop_word_t w);
    @(negedge mclk) conv_start = 1'b1;
    @(negedge mclk) conv_start = 1'b0;
    repeat (4) @(negedge mclk);
    conv_result = w;
    conv_done = 1'b1;
    @(negedge mclk) conv_done = 1'b0;
  endtask
  task automatic frame(input logic sl, inv, fmt, rdc, input asop_pkg::asop_word_t w);
    logic [15:0] coded;
    coded = fmt ? w : w ^ 16'h8000;
    @(negedge mclk);
    {pss, css, cis, ocf, rmc} = {1'b1, sl, inv, fmt, rdc};
    repeat (10) @(negedge mclk);
    if (sl || rdc) conv(w);
    go = 1'b1;
    repeat (10) @(negedge mclk);
    conv(rdc ? ~w : w);
    repeat (40) @(negedge mclk);
    cmp(32'({frame_active, data_pin_oe_n[3:2]}), 32'({1'b1, sl, 1'b0}), "oe");
    repeat (400) @(negedge mclk);
    if (sl)
      cmp({rx_count[11:0], rx_word[19:0]}, {12'h014, coded, {4{rdc}}},
          "slave");
    else
      cmp({rx_count[14:0], data_pin_o[3], rx_word[15:0]}, {15'h0010, inv, coded},
          "master");
    go = 1'b0;
    repeat (10) @(negedge mclk);
    cmp(32'(frame_active), 32'h0, "idle");
  endtask

  // -----------------------------
  // tests
  // -----------------------------
  initial begin
    {reset_n, pss, cis, rmc, css, ocf, go, conv_start, conv_done} = '0;
    conv_result = 16'h0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (5) @(negedge mclk);
    ocf = 1'b1;
    conv(16'h83c0);
    repeat (6) @(negedge mclk);
    cmp(32'({data_pin_oe_n, data_pin_o}), 32'h0f, "parallel");
    conv(16'h0240);
    repeat (6) @(negedge mclk);
    cmp(32'({data_pin_oe_n, data_pin_o}), 32'h09, "parallel");
    frame(1'b0, 1'b0, 1'b1, 1'b0, 16'hc3a5);
    frame(1'b0, 1'b1, 1'b0, 1'b0, 16'h35ca);
    frame(1'b0, 1'b0, 1'b0, 1'b1, 16'h9e01);
    frame(1'b1, 1'b0, 1'b0, 1'b0, 16'h8421);
    frame(1'b1, 1'b1, 1'b1, 1'b1, 16'h7bde);
    conclude();
  end
endmodule
`default_nettype wire
